// ===== verilog/smc_map.svh
// sleep controller register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned registers
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SMC_CTRL_OFF        12'h000
`define SMC_STATUS_OFF      12'h004
`define SMC_CFG_OFF         12'h008
`define SMC_STARTUP_OFF     12'h00c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SMC_SE_BIT          0
`define SMC_SM_LSB          1
`define SMC_SM_MSB          3
`define SMC_CTRL_MASK       32'h0000000f
`define SMC_CTRL_RESET      32'h00000000

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define SMC_CFG_XTAL_BIT    0
`define SMC_CFG_T2ASY_BIT   1
`define SMC_CFG_LCDASY_BIT  2
`define SMC_CFG_T2EN_BIT    3
`define SMC_CFG_LCDEN_BIT   4
`define SMC_CFG_ADCEN_BIT   5
`define SMC_CFG_MASK        32'h0000003f
`define SMC_CFG_RESET       32'h00000000

// ----------------------------------------
// timing
// ----------------------------------------
`define SMC_CLK_PERIOD_NS   5
`define SMC_HALT_CYCLES     4
`define SMC_STANDBY_CYCLES  6
`define SMC_STARTUP_RESET   16'h0040

`endif

// ===== verilog/smc_pkg.sv
// sleep controller types shared by the design and the bench
// no assumptions beyond a systemverilog compiler
`default_nettype none
package smc_pkg;

	typedef enum logic [2:0] {
		SMC_MODE_IDLE     = 3'b000,
		SMC_MODE_QUIET    = 3'b001,
		SMC_MODE_PDOWN    = 3'b010,
		SMC_MODE_PSAVE    = 3'b011,
		SMC_MODE_RSV4     = 3'b100,
		SMC_MODE_RSV5     = 3'b101,
		SMC_MODE_STANDBY  = 3'b110,
		SMC_MODE_RSV7     = 3'b111
	} smc_mode_t;

	typedef enum logic [1:0] {
		SMC_ST_RUN   = 2'b00,
		SMC_ST_SLEEP = 2'b01,
		SMC_ST_START = 2'b10,
		SMC_ST_HALT  = 2'b11
	} smc_state_t;

	// clock and oscillator gates, high = running
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic timer_osc;
	} smc_gates_t;

	// wake-up sources, each a level from its peripheral
	typedef struct packed {
		logic ext_irq_zero_level;
		logic ext_irq_zero_edge;
		logic pin_change;
		logic serial_start;
		logic lcd;
		logic timer2;
		logic spm_ee_ready;
		logic adc_done;
		logic other_io;
	} smc_wake_t;

endpackage
`default_nettype wire

// ===== verilog/smc_sleep_ctrl.sv
// sleep-mode controller: gates clocks and oscillators per mode, wakes the core on qualified sources
// assumes the core pulses sleep_exec when the sleep instruction executes and honours cpu_halt
//
// Behaviour
// R1: software sets sleep enable then executes sleep; with enable clear, no sleep.
// R2: the three-bit mode field is sampled at the sleep instruction.
// R3: enabled interrupt wakes core; halt four cycles past start-up, then resume.
// R4: register file and static memory are never disturbed by sleep.
// R5: reset during sleep wakes device; execution starts at reset vector.
// R6: mode 000 idle stops only core and program-memory clocks; the code also stops timer_osc unless use_asy is set.
// R7: in idle any enabled interrupt wakes the core.
// R8: converter enabled: entering idle or quiet mode starts a conversion.
// R9: mode 001 quiet stops io, core and program-memory clocks.
// R10: quiet mode wakes only on its listed sources.
// R11: mode 010 power-down stops oscillator and all generated clocks.
// R12: power-down ends only on reset, serial start, level irq zero, pin change.
// R13: a level wake source must hold its level until recognised.
// R14: power-down wake waits the fuse-selected start-up period.
// R15: mode 011 power-save is power-down plus timer two and display.
// R16: power-save wakes on timer two (enabled) or display interrupt.
// R17: software should prefer power-down when neither module runs.
// R18: power-save stops timer oscillator unless a module uses asynchronous clock.
// R19: power-save stops main clock unless a module uses synchronous clock.
// R20: mode 110 with crystal is standby; oscillator runs, wake in six cycles.
// R21: outside idle, irq zero wakes only when level triggered.
// R22: mode field at bits 3..1, sleep enable at bit 0.
// R23: reserved mode codes do not sleep; execution continues.
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"

module smc_sleep_ctrl
	import smc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// core side
	input  wire logic        sleep_exec,
	input  wire logic        global_irq_en,
	input  wire logic        timer2_irq_mask,
	input  wire smc_wake_t   wake_src,
	output logic             cpu_halt,
	output logic             irq_resume,
	output logic             adc_start,
	output smc_gates_t       gates
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [3:0]  sleep_control_reg;
	logic [5:0]  cfg_reg;
	logic [15:0] startup_reg;
	smc_state_t  state_reg;
	smc_state_t  state_next;
	smc_mode_t   mode_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	smc_gates_t  gates_next;
	logic        wake;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        sleep_go;
	smc_mode_t   mode_sel;
	logic        t2_on;
	logic        lcd_on;
	logic        use_asy;
	logic        use_sync;
	logic [2:0]  wake_cnt;

	assign mode_sel = smc_mode_t'(sleep_control_reg[`SMC_SM_MSB:`SMC_SM_LSB]); // R22
	assign t2_on    = cfg_reg[`SMC_CFG_T2EN_BIT];
	assign lcd_on   = cfg_reg[`SMC_CFG_LCDEN_BIT];
	assign use_asy  = (t2_on && cfg_reg[`SMC_CFG_T2ASY_BIT]) || (lcd_on && cfg_reg[`SMC_CFG_LCDASY_BIT]);
	assign use_sync = (t2_on && !cfg_reg[`SMC_CFG_T2ASY_BIT]) || (lcd_on && !cfg_reg[`SMC_CFG_LCDASY_BIT]);

	// ----------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------
	assign addr_ok = (paddr == `SMC_CTRL_OFF) || (paddr == `SMC_STATUS_OFF) ||
	                 (paddr == `SMC_CFG_OFF) || (paddr == `SMC_STARTUP_OFF);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en   = psel && penable && pwrite && addr_ok;
	assign rd_en   = psel && !penable && !pwrite;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_control_reg <= 4'h0;
		end else if (wr_en && paddr == `SMC_CTRL_OFF) begin
			sleep_control_reg <= pwdata[3:0]; // R22
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= 6'h00;
		end else if (wr_en && paddr == `SMC_CFG_OFF) begin
			cfg_reg <= pwdata[5:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			startup_reg <= `SMC_STARTUP_RESET;
		end else if (wr_en && paddr == `SMC_STARTUP_OFF) begin
			startup_reg <= pwdata[15:0];
		end
	end

	// read data captured in the setup phase so it comes from a flop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			case (paddr)
				`SMC_CTRL_OFF:    prdata <= {28'h0000000, sleep_control_reg};
				`SMC_STATUS_OFF:  prdata <= {24'h000000, 1'b0, mode_reg, 2'b00, state_reg};
				`SMC_CFG_OFF:     prdata <= {26'h0000000, cfg_reg};
				`SMC_STARTUP_OFF: prdata <= {16'h0000, startup_reg};
				default:          prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// sleep entry and wake qualification
	// ----------------------------------------
	// reserved codes and standby without a crystal never sleep
	always_comb begin
		sleep_go = 1'b0;
		if (sleep_exec && sleep_control_reg[`SMC_SE_BIT]) begin // R1
			case (mode_sel)
				SMC_MODE_IDLE, SMC_MODE_QUIET, SMC_MODE_PDOWN, SMC_MODE_PSAVE: sleep_go = 1'b1;
				SMC_MODE_STANDBY: sleep_go = cfg_reg[`SMC_CFG_XTAL_BIT]; // R20
				default:          sleep_go = 1'b0; // R23
			endcase
		end
	end

	// sources are levels; a source must stay up until sampled
	always_comb begin
		case (mode_reg)
			SMC_MODE_IDLE: begin
				wake = wake_src.ext_irq_zero_level || wake_src.ext_irq_zero_edge || // R7
				       wake_src.pin_change || wake_src.serial_start || wake_src.lcd ||
				       wake_src.timer2 || wake_src.spm_ee_ready || wake_src.adc_done ||
				       wake_src.other_io;
			end
			SMC_MODE_QUIET: begin
				wake = wake_src.adc_done || wake_src.ext_irq_zero_level || // R10 R21
				       wake_src.pin_change || wake_src.serial_start || wake_src.lcd ||
				       wake_src.timer2 || wake_src.spm_ee_ready;
			end
			SMC_MODE_PSAVE: begin
				wake = wake_src.ext_irq_zero_level || wake_src.pin_change || // R21
				       wake_src.serial_start || wake_src.lcd || // R16
				       (wake_src.timer2 && timer2_irq_mask && global_irq_en); // R16
			end
			default: begin
				wake = wake_src.ext_irq_zero_level || wake_src.pin_change || // R12 R21
				       wake_src.serial_start;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// standby wakes in a fixed count; power-down and power-save wait the start-up period
	always_comb begin
		wake_cnt = 3'(`SMC_HALT_CYCLES);
		if (mode_reg == SMC_MODE_STANDBY) begin
			wake_cnt = 3'(`SMC_STANDBY_CYCLES); // R20
		end
	end

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			SMC_ST_RUN: begin
				if (sleep_go) begin
					state_next = SMC_ST_SLEEP;
				end
			end
			SMC_ST_SLEEP: begin
				if (wake) begin
					if (mode_reg == SMC_MODE_PDOWN || mode_reg == SMC_MODE_PSAVE) begin
						state_next = SMC_ST_START; // R14
						cnt_next   = startup_reg;
					end else begin
						state_next = SMC_ST_HALT; // R3
						cnt_next   = {13'h0000, wake_cnt};
					end
				end
			end
			SMC_ST_START: begin
				if (cnt_reg <= 16'h0001) begin
					state_next = SMC_ST_HALT; // R3
					cnt_next   = 16'(`SMC_HALT_CYCLES);
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			SMC_ST_HALT: begin
				if (cnt_reg <= 16'h0001) begin
					state_next = SMC_ST_RUN;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			default: begin
				state_next = SMC_ST_RUN;
			end
		endcase
	end

	// reset from any state lands in run, so the core restarts at its reset vector
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SMC_ST_RUN; // R5
			cnt_reg   <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= SMC_MODE_IDLE;
		end else if (state_reg == SMC_ST_RUN && sleep_go) begin
			mode_reg <= mode_sel; // R2
		end
	end

	// one pulse on resume: the core takes the pending interrupt, then the next instruction
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_resume <= 1'b0;
		end else begin
			irq_resume <= (state_reg == SMC_ST_HALT) && (state_next == SMC_ST_RUN); // R3
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_start <= 1'b0;
		end else begin
			// a sleep strobe while already halted must not start a second conversion
			adc_start <= (state_reg == SMC_ST_RUN) && sleep_go && cfg_reg[`SMC_CFG_ADCEN_BIT] && // R8
			             (mode_sel == SMC_MODE_IDLE || mode_sel == SMC_MODE_QUIET);
		end
	end

	// ----------------------------------------
	// clock gating
	// ----------------------------------------
	// only clocks are gated, never storage, so register file and memory keep their data
	always_comb begin
		gates_next = '{default: 1'b1}; // R4
		if (state_next == SMC_ST_SLEEP || state_next == SMC_ST_START) begin
			case (state_next == SMC_ST_SLEEP ? mode_sel_eff() : mode_reg)
				SMC_MODE_IDLE: begin
					gates_next.cpu       = 1'b0; // R6
					gates_next.flash     = 1'b0;
					gates_next.timer_osc = use_asy;
				end
				SMC_MODE_QUIET: begin
					gates_next.cpu       = 1'b0; // R9
					gates_next.flash     = 1'b0;
					gates_next.io        = 1'b0;
					gates_next.timer_osc = use_asy;
				end
				SMC_MODE_PSAVE: begin
					gates_next           = '{default: 1'b0}; // R15
					gates_next.asy       = use_asy;
					gates_next.timer_osc = use_asy; // R18
					gates_next.main_osc  = use_sync; // R19
				end
				SMC_MODE_STANDBY: begin
					gates_next          = '{default: 1'b0};
					gates_next.main_osc = 1'b1; // R20
				end
				default: begin
					gates_next = '{default: 1'b0}; // R11
				end
			endcase
			// oscillator restarts during the start-up wait
			if (state_next == SMC_ST_START) begin
				gates_next.main_osc = 1'b1; // R14
			end
		end
	end

	function automatic smc_mode_t mode_sel_eff();
		mode_sel_eff = (state_reg == SMC_ST_RUN) ? mode_sel : mode_reg;
	endfunction

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gates <= '{default: 1'b1};
		end else begin
			gates <= gates_next;
		end
	end

	assign cpu_halt = (state_reg != SMC_ST_RUN);

endmodule
`default_nettype wire

// ===== verification/smc_sleep_ctrl_asserts.sv
// concurrent checks on the sleep controller ports
// assumes it is bound into smc_sleep_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
module smc_sleep_ctrl_asserts
	import smc_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        sleep_exec,
	input wire smc_wake_t   wake_src,
	input wire logic        cpu_halt,
	input wire logic        irq_resume,
	input wire smc_gates_t  gates
);
	logic       se_reg;
	logic [2:0] mode_reg;
	logic       take;
	// shadow of the control word, so entry can be predicted from the bus
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			se_reg   <= 1'b0;
			mode_reg <= 3'b000;
		end else if (psel && penable && pwrite && paddr == `SMC_CTRL_OFF) begin
			se_reg   <= pwdata[0];
			mode_reg <= pwdata[3:1];
		end
	end
	assign take = sleep_exec && !cpu_halt && se_reg;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_sleep_needs_enable: assert property (sleep_exec && !cpu_halt && !se_reg |=> !cpu_halt)
		else $error("sleep entered with enable clear");
	a_reserved_no_sleep: assert property (take && mode_reg inside {3'b100, 3'b101, 3'b111} |=> !cpu_halt)
		else $error("reserved mode entered sleep");
	a_idle_gates: assert property (take && mode_reg == 3'b000 |=> cpu_halt && !gates.cpu && !gates.flash && gates.io)
		else $error("idle gating wrong");
	a_quiet_gates: assert property (take && mode_reg == 3'b001 |=> cpu_halt && !gates.io && gates.adc)
		else $error("quiet gating wrong");
	a_pdown_stops: assert property (take && mode_reg == 3'b010 |=> cpu_halt && !gates.main_osc && !gates.asy)
		else $error("power-down left a clock running");
	a_resume_pulse: assert property (irq_resume |=> !irq_resume)
		else $error("resume longer than one cycle");
	a_resume_follows: assert property ($fell(cpu_halt) |-> ##[0:1] irq_resume)
		else $error("halt ended without resume");
	a_pdown_guard: assert property (cpu_halt && !gates.main_osc && !(wake_src.ext_irq_zero_level ||
		wake_src.pin_change || wake_src.serial_start || wake_src.lcd || wake_src.timer2) |=> !gates.main_osc)
		else $error("deep sleep left on a disallowed source");
	c_idle: cover property (take && mode_reg == 3'b000);
	c_pdown: cover property (take && mode_reg == 3'b010);
	c_resume: cover property (irq_resume);
endmodule
`default_nettype wire

// ===== verification/smc_core_model.sv
// core and wake-source stand-in facing the sleep controller
// assumes the bench requests a sleep with a one-cycle go pulse
`timescale 1ns/1ps
`default_nettype none
module smc_core_model
	import smc_pkg::*;
(
	input wire logic      core_clk,
	input wire logic      rst_n,
	input wire logic      go_sleep,
	input wire smc_wake_t wake_req,
	input wire logic      irq_resume,
	output logic          sleep_exec,
	output smc_wake_t     wake_src
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_exec <= 1'b0;
		end else begin
			sleep_exec <= go_sleep;
		end
	end
	// a source keeps its level until the handler runs, so no wake is lost
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_src <= '0;
		end else begin
			wake_src <= irq_resume ? '0 : (wake_src | wake_req);
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb_sleep_mode_controller.sv
// self-checking bench: apb master, core model, per-mode entry and wake
// assumes the controller, core model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_sleep_mode_controller;
	import smc_pkg::*;
	logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slv;
	logic        global_irq_en = 0, timer2_irq_mask = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, rng = 32'h372e7359, prdata;
	logic        pready, pslverr, sleep_exec, cpu_halt, irq_resume, adc_start;
	smc_wake_t   wake_src, wreq = '0;
	smc_gates_t  gates;
	int          n_mismatch = 0, checks = 0, k, st, n_adc, n_res = 0, ex_res = 0;
	logic [2:0]  md [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b110};
	logic [8:0]  bad [5] = '{9'h000, 9'h001, 9'h080, 9'h008, 9'h010};
	logic [8:0]  good [5] = '{9'h080, 9'h002, 9'h100, 9'h010, 9'h020};
	logic [3:0]  g4 [5] = '{4'b0011, 4'b0001, 4'b0000, 4'b0001, 4'b0001};
	int          lat_q [$];
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (adc_start === 1'b1) n_adc++;
		if (irq_resume === 1'b1) n_res++;
	end
	smc_sleep_ctrl uut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sleep_exec, .global_irq_en, .timer2_irq_mask, .wake_src, .cpu_halt, .irq_resume,
		.adc_start, .gates);
	smc_core_model partner (.core_clk, .rst_n, .go_sleep(go), .wake_req(wreq), .irq_resume, .sleep_exec,
		.wake_src);
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// latency model: halt cycles the bench expects, from the mode and the start-up count st
	function automatic int model_lat(input logic [2:0] m);
		if (m == 3'b110) return `SMC_STANDBY_CYCLES;
		if (m == 3'b010 || m == 3'b011) return st + `SMC_HALT_CYCLES;
		return `SMC_HALT_CYCLES;
	endfunction
	task test_done;
		if (n_mismatch == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----
	// bus and sleep helpers
	// ----
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		k = 0;
		do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 50);
		rd = prdata; slv = pslverr;
		psel <= 0; penable <= 0;
		if (k >= 50) begin n_mismatch++; test_done; end
	endtask
	task sleep_in(input logic [2:0] m, input logic se, input logic exp);
		apb(1, `SMC_CTRL_OFF, {rng[31:4], m, se});
		rng = xs(rng);
		#1 n_adc = 0;
		@(posedge core_clk);
		go <= 1;
		@(posedge core_clk);
		go <= 0;
		repeat (4) @(posedge core_clk);
		#1 `CHK("halt", exp, cpu_halt)
		if (exp) lat_q.push_back(model_lat(m));
	endtask
	// lat 0 means the source must be ignored
	task wake(input logic [8:0] s, input int lat);
		@(posedge core_clk);
		wreq <= smc_wake_t'(s);
		k = 0;
		do begin @(posedge core_clk); wreq <= '0; k++; #1; end while (cpu_halt === 1'b1 && k < 40);
		`CHK("wake_cycles", lat ? lat + 2 : 40, k)
		if (lat) begin
			repeat (2) @(posedge core_clk);
			ex_res++;
			`CHK("resume", ex_res, n_res)
		end
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1;
		apb(0, `SMC_STARTUP_OFF, '0); `CHK("startup", `SMC_STARTUP_RESET, rd[15:0])
		apb(0, 12'h010, '0); `CHK("unmapped", 2'b10, {slv, |rd})
		st = 2 + rng[2:0];
		apb(1, `SMC_STARTUP_OFF, st);
		apb(1, `SMC_CTRL_OFF, rng);
		apb(0, `SMC_CTRL_OFF, '0); `CHK("ctrl", rng & 32'hf, rd)
		rng = xs(rng);
		sleep_in(3'b000, 0, 0);
		for (int i = 4; i < 8; i++) sleep_in(i[2:0], 1, 0);
		// display on the main clock, so power-save is not chosen where power-down would do
		apb(1, `SMC_CFG_OFF, 32'h31);
		for (int i = 0; i < 5; i++) begin
			sleep_in(md[i], 1, 1);
			`CHK("gates", g4[i], {gates.cpu, gates.flash, gates.io, gates.main_osc})
			`CHK("adc_start", int'(i < 2), n_adc)
			wake(bad[i], 0);
			wake(good[i], lat_q.pop_front());
			`CHK("resumed", 7'h7f, gates)
		end
		sleep_in(3'b010, 1, 1);
		@(posedge core_clk);
		rst_n <= 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		#1 `CHK("reset_wake", 8'h7f, {cpu_halt, gates})
		apb(0, `SMC_CTRL_OFF, '0); `CHK("ctrl_rst", 32'h0, rd)
		test_done;
	end
endmodule
bind smc_sleep_ctrl smc_sleep_ctrl_asserts chk (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.sleep_exec, .wake_src, .cpu_halt, .irq_resume, .gates);
`default_nettype wire
